// ---- chan_irq_consts.vh ----
// Constants for the channel control and interrupt flag block.
// Assumes a 32-bit AHB-Lite slave; every register takes one aligned word.
`ifndef CHAN_IRQ_CONSTS_VH
`define CHAN_IRQ_CONSTS_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_START_TRIG   8'h00
`define OFS_STOP_TRIG    8'h04
`define OFS_CHAN_STATUS  8'h08
`define OFS_UART_FLAGS   8'h0C
`define OFS_UART_MASKS   8'h10
`define OFS_TMR_FLAGS    8'h14
`define OFS_TMR_MASKS    8'h18
`define OFS_TMR_CTRL     8'h1C
`define OFS_PER_ENABLE   8'h20
`define OFS_PORT6_DATA   8'h24
`define OFS_PORT6_MODE   8'h28
`define OFS_SER_OUT_EN   8'h2C
`define OFS_MEAS_FLAGS   8'h30
`define OFS_MEAS_MASKS   8'h34
`define OFS_MEAS_CTRL    8'h38

// ****************************************************************
// Field positions
// ****************************************************************
`define BIT_UART_ERR     5
`define BIT_UART_RX      2
`define BIT_UART_TX      1
`define BIT_TMR0         0
`define BIT_TMR_RUN      0
`define BIT_MEAS_CLK     6
`define BIT_MEAS_FLAG    0
`define BIT_MEAS_RUN     7
`define BIT_PIN0         0

// ****************************************************************
// Fixed bits and reset values
// ****************************************************************
`define UART_MASK_FIXED  8'h18
`define RST_MASK_BIT     1'b1
`define RST_PORT6_DATA   4'h0
`define RST_PORT6_MODE   4'hF
`define RST_SER_OUT      2'h0
`define RST_CHAN_EN      2'h0

`endif

// ---- chan_irq_ctrl.v ----
// Channel start/stop control, interrupt request flags and masks, timer
// run bit, measurement clock gate and a port pin, behind AHB-Lite.
// Assumes event inputs are one-cycle pulses from logic on hclk.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`include "chan_irq_consts.vh"

// Functional notes
// R01: Start trigger write of 1 sets channel enable status; 0 does nothing.
// R02: Stop trigger write of 1 clears channel enable status; 0 does nothing.
// R03: Each request flag reads 1 while its request is pending, else 0.
// R04: UART error, receive, transmit at bits 5,2,1; mask 0 enables.
// R05: Software clears UART flags before unmasking them.
// R06: Timer channel 0 flag and mask at bit 0; clear then unmask.
// R07: Timer control bit 0 runs the interval timer count when 1.
// R08: To stop timer software masks, clears flag, then clears run bit.
// R09: Peripheral enable bit 6 gates measurement input clock; 1 enables.
// R10: Software supplies measurement clock only while a measurement runs.
// R11: Serial output enable bit 0 enables channel serial output when 1.
// R12: Indicator pin driven low during correction, released afterwards.
// R13: UART stop: mask, stop both channels, output off, clear flags.
// R14: Measurement flag at bit 0; software clears it before enabling.
// R15: Measurement control bit 7 enables measurement circuit when 1.
// R16: Measurement mask bit 0 enables servicing at 0, disables at 1.
// R17: Software keeps other bits of shared registers when updating one.
module chan_irq_ctrl (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  uart_err_evt,
  uart_rx_evt,
  uart_tx_evt,
  timer_evt,
  measure_evt,
  uart_err_req,
  uart_rx_req,
  uart_tx_req,
  timer_req,
  measure_req,
  channel_enable_status,
  serial_output_on,
  timer_count_run,
  measure_clock_gate,
  measure_circuit_run,
  port_six_out,
  correction_indicator_pin_i,
  correction_indicator_pin_o,
  correction_indicator_pin_oe
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        hsel;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output wire        hreadyout;
  output wire        hresp;
  output wire [31:0] hrdata;
  input  wire        uart_err_evt;
  input  wire        uart_rx_evt;
  input  wire        uart_tx_evt;
  input  wire        timer_evt;
  input  wire        measure_evt;
  output wire        uart_err_req;
  output wire        uart_rx_req;
  output wire        uart_tx_req;
  output wire        timer_req;
  output wire        measure_req;
  output wire [1:0]  channel_enable_status;
  output wire [1:0]  serial_output_on;
  output wire        timer_count_run;
  output wire        measure_clock_gate;
  output wire        measure_circuit_run;
  output wire [3:0]  port_six_out;
  input  wire        correction_indicator_pin_i;
  output wire        correction_indicator_pin_o;
  output wire        correction_indicator_pin_oe;

  // ****************************************************************
  // Bus state machine
  // ****************************************************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_WRITE = 4'b0010;
  localparam [3:0] ST_RWAIT = 4'b0100;
  localparam [3:0] ST_RDATA = 4'b1000;

  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a[7:2] == ofs[7:2]);
    end
  endfunction

  reg  [3:0]  state_q;
  reg  [3:0]  state_d;
  reg  [7:0]  addr_q;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;
  wire        take;
  wire        wr;

  assign take      = hsel & hready & htrans[1];
  assign hreadyout = ~state_q[2];
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;
  assign wr        = state_q[1];

  always @* begin
    state_d = ST_IDLE;
    case (state_q)
      ST_RWAIT: state_d = ST_RDATA;
      default: begin
        if (take) begin
          state_d = hwrite ? ST_WRITE : ST_RWAIT;
        end
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      addr_q  <= 8'h00;
    end else begin
      state_q <= state_d;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  reg  [1:0] chan_en_q;
  reg  [1:0] soe_q;
  reg        tmr_run_q;
  reg        meas_clk_q;
  reg        meas_run_q;
  reg  [3:0] p6_data_q;
  reg  [3:0] p6_mode_q;
  reg        uerr_mk_q;
  reg        urx_mk_q;
  reg        utx_mk_q;
  reg        tmr_mk_q;
  reg        meas_mk_q;
  wire [1:0] start_bits;
  wire [1:0] stop_bits;

  assign start_bits = (wr && hit(addr_q, `OFS_START_TRIG)) ?
                      hwdata[1:0] : 2'h0;
  assign stop_bits  = (wr && hit(addr_q, `OFS_STOP_TRIG)) ?
                      hwdata[1:0] : 2'h0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_en_q  <= `RST_CHAN_EN;
      soe_q      <= `RST_SER_OUT;
      tmr_run_q  <= 1'b0;
      meas_clk_q <= 1'b0;
      meas_run_q <= 1'b0;
      p6_data_q  <= `RST_PORT6_DATA;
      p6_mode_q  <= `RST_PORT6_MODE;
      uerr_mk_q  <= `RST_MASK_BIT;
      urx_mk_q   <= `RST_MASK_BIT;
      utx_mk_q   <= `RST_MASK_BIT;
      tmr_mk_q   <= `RST_MASK_BIT;
      meas_mk_q  <= `RST_MASK_BIT;
    end else begin
      // Stop wins when both triggers hit the same channel together
      chan_en_q <= (chan_en_q | start_bits) & ~stop_bits; // R01 R02
      if (wr) begin
        if (hit(addr_q, `OFS_SER_OUT_EN)) begin
          soe_q <= hwdata[1:0]; // R11
        end else if (hit(addr_q, `OFS_TMR_CTRL)) begin
          tmr_run_q <= hwdata[`BIT_TMR_RUN]; // R07
        end else if (hit(addr_q, `OFS_PER_ENABLE)) begin
          meas_clk_q <= hwdata[`BIT_MEAS_CLK]; // R09
        end else if (hit(addr_q, `OFS_MEAS_CTRL)) begin
          meas_run_q <= hwdata[`BIT_MEAS_RUN]; // R15
        end else if (hit(addr_q, `OFS_PORT6_DATA)) begin
          p6_data_q <= hwdata[3:0];
        end else if (hit(addr_q, `OFS_PORT6_MODE)) begin
          p6_mode_q <= hwdata[3:0];
        end else if (hit(addr_q, `OFS_UART_MASKS)) begin
          uerr_mk_q <= hwdata[`BIT_UART_ERR]; // R04
          urx_mk_q  <= hwdata[`BIT_UART_RX];
          utx_mk_q  <= hwdata[`BIT_UART_TX];
        end else if (hit(addr_q, `OFS_TMR_MASKS)) begin
          tmr_mk_q <= hwdata[`BIT_TMR0]; // R06
        end else if (hit(addr_q, `OFS_MEAS_MASKS)) begin
          meas_mk_q <= hwdata[`BIT_MEAS_FLAG]; // R16
        end
      end
    end
  end

  // ****************************************************************
  // Request flags
  // ****************************************************************
  reg  uerr_if_q;
  reg  urx_if_q;
  reg  utx_if_q;
  reg  tmr_if_q;
  reg  meas_if_q;
  wire wr_uf;
  wire wr_tf;
  wire wr_mf;
  wire tmr_set;
  wire meas_set;

  assign wr_uf = wr & hit(addr_q, `OFS_UART_FLAGS);
  assign wr_tf = wr & hit(addr_q, `OFS_TMR_FLAGS);
  assign wr_mf = wr & hit(addr_q, `OFS_MEAS_FLAGS);
  // Timer and measurement only raise events while they run
  assign tmr_set  = timer_evt & tmr_run_q;
  assign meas_set = measure_evt & meas_run_q & meas_clk_q;

  // Hardware set wins over a software write in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uerr_if_q <= 1'b0;
      urx_if_q  <= 1'b0;
      utx_if_q  <= 1'b0;
      tmr_if_q  <= 1'b0;
      meas_if_q <= 1'b0;
    end else begin
      uerr_if_q <= (wr_uf ? hwdata[`BIT_UART_ERR] : uerr_if_q) |
                   uart_err_evt; // R03
      urx_if_q  <= (wr_uf ? hwdata[`BIT_UART_RX] : urx_if_q) |
                   uart_rx_evt; // R03
      utx_if_q  <= (wr_uf ? hwdata[`BIT_UART_TX] : utx_if_q) |
                   uart_tx_evt; // R03
      tmr_if_q  <= (wr_tf ? hwdata[`BIT_TMR0] : tmr_if_q) |
                   tmr_set; // R06
      meas_if_q <= (wr_mf ? hwdata[`BIT_MEAS_FLAG] : meas_if_q) |
                   meas_set; // R14
    end
  end

  // Pending requests forwarded only while unmasked
  assign uart_err_req = uerr_if_q & ~uerr_mk_q; // R04
  assign uart_rx_req  = urx_if_q & ~urx_mk_q; // R04
  assign uart_tx_req  = utx_if_q & ~utx_mk_q; // R04
  assign timer_req    = tmr_if_q & ~tmr_mk_q; // R06
  assign measure_req  = meas_if_q & ~meas_mk_q; // R16

  // ****************************************************************
  // Port pin
  // ****************************************************************
  wire pin_sync;

  sync2 #(
    .W (1)
  ) u_pin_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (correction_indicator_pin_i),
    .q       (pin_sync)
  );

  // Mode bit 1 releases the pin; 0 drives the data bit
  assign correction_indicator_pin_o  = p6_data_q[`BIT_PIN0];
  assign correction_indicator_pin_oe = ~p6_mode_q[`BIT_PIN0];
  assign port_six_out                = p6_data_q;

  // ****************************************************************
  // Read data
  // ****************************************************************
  reg [3:0] p6_rd;

  always @* begin
    p6_rd = p6_data_q;
    if (p6_mode_q[`BIT_PIN0]) begin
      p6_rd[`BIT_PIN0] = pin_sync;
    end
    rdata_d = 32'h00000000;
    if (hit(addr_q, `OFS_CHAN_STATUS)) begin
      rdata_d[1:0] = chan_en_q;
    end else if (hit(addr_q, `OFS_UART_FLAGS)) begin
      rdata_d[`BIT_UART_ERR] = uerr_if_q;
      rdata_d[`BIT_UART_RX]  = urx_if_q;
      rdata_d[`BIT_UART_TX]  = utx_if_q;
    end else if (hit(addr_q, `OFS_UART_MASKS)) begin
      rdata_d[7:0]           = `UART_MASK_FIXED;
      rdata_d[`BIT_UART_ERR] = uerr_mk_q;
      rdata_d[`BIT_UART_RX]  = urx_mk_q;
      rdata_d[`BIT_UART_TX]  = utx_mk_q;
    end else if (hit(addr_q, `OFS_TMR_FLAGS)) begin
      rdata_d[`BIT_TMR0] = tmr_if_q;
    end else if (hit(addr_q, `OFS_TMR_MASKS)) begin
      rdata_d[`BIT_TMR0] = tmr_mk_q;
    end else if (hit(addr_q, `OFS_TMR_CTRL)) begin
      rdata_d[`BIT_TMR_RUN] = tmr_run_q;
    end else if (hit(addr_q, `OFS_PER_ENABLE)) begin
      rdata_d[`BIT_MEAS_CLK] = meas_clk_q;
    end else if (hit(addr_q, `OFS_PORT6_DATA)) begin
      rdata_d[3:0] = p6_rd;
    end else if (hit(addr_q, `OFS_PORT6_MODE)) begin
      rdata_d[3:0] = p6_mode_q;
    end else if (hit(addr_q, `OFS_SER_OUT_EN)) begin
      rdata_d[1:0] = soe_q;
    end else if (hit(addr_q, `OFS_MEAS_FLAGS)) begin
      rdata_d[`BIT_MEAS_FLAG] = meas_if_q;
    end else if (hit(addr_q, `OFS_MEAS_MASKS)) begin
      rdata_d[`BIT_MEAS_FLAG] = meas_mk_q;
    end else if (hit(addr_q, `OFS_MEAS_CTRL)) begin
      rdata_d[`BIT_MEAS_RUN] = meas_run_q;
    end
  end

  // Captured in the wait cycle so a write just before is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h00000000;
    end else if (state_q[2]) begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign channel_enable_status = chan_en_q;
  assign serial_output_on      = soe_q; // R11
  assign timer_count_run       = tmr_run_q; // R07
  assign measure_clock_gate    = meas_clk_q; // R09
  assign measure_circuit_run   = meas_run_q; // R15

endmodule // chan_irq_ctrl

// ---- chan_irq_ctrl_asserts.sv ----
// Checker for chan_irq_ctrl: bus timing, triggers and control bits.
// Assumes it is bound to chan_irq_ctrl and sees only its ports.
`timescale 1ns/10ps
`include "chan_irq_consts.vh"

module chan_irq_chk (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        uart_err_req,
  input wire        uart_rx_req,
  input wire        uart_tx_req,
  input wire [1:0]  channel_enable_status,
  input wire [1:0]  serial_output_on,
  input wire        timer_count_run,
  input wire        measure_clock_gate,
  input wire        measure_circuit_run
);
  reg        wph_q;
  reg  [7:0] adr_q;
  wire       take = hsel && hready && htrans[1];
  wire [2:0] ureq = {uart_err_req, uart_rx_req, uart_tx_req};

  // ********
  // Write data phase tracking
  // ********
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wph_q <= take && hwrite;
      adr_q <= haddr[7:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RD_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not one wait cycle");
  AST_WR_ZERO_WAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_OKAY: assert property (!hresp)
    else $error("response not okay");
  AST_START_SETS: assert property (
    wph_q && adr_q == `OFS_START_TRIG && hwdata[0]
    |=> channel_enable_status[0]) else $error("start did not enable");
  AST_STOP_CLEARS: assert property (
    wph_q && adr_q == `OFS_STOP_TRIG && hwdata[1]
    |=> !channel_enable_status[1]) else $error("stop did not disable");
  AST_STATUS_HOLD: assert property (
    !(wph_q && (adr_q == `OFS_START_TRIG || adr_q == `OFS_STOP_TRIG))
    |=> $stable(channel_enable_status)) else $error("status changed");
  AST_TMR_RUN: assert property (
    wph_q && adr_q == `OFS_TMR_CTRL |=> timer_count_run == $past(hwdata[0]))
    else $error("timer run bit wrong");
  AST_MEAS_GATE: assert property (
    wph_q && adr_q == `OFS_PER_ENABLE
    |=> measure_clock_gate == $past(hwdata[6])) else $error("gate wrong");
  AST_MEAS_RUN: assert property (
    wph_q && adr_q == `OFS_MEAS_CTRL
    |=> measure_circuit_run == $past(hwdata[7])) else $error("run wrong");
  AST_SER_OUT: assert property (
    wph_q && adr_q == `OFS_SER_OUT_EN
    |=> serial_output_on == $past(hwdata[1:0])) else $error("output wrong");
  AST_REQ_HOLD: assert property (
    !wph_q |=> (ureq & $past(ureq)) == $past(ureq))
    else $error("pending request dropped without a write");
endmodule // chan_irq_chk

bind chan_irq_ctrl chan_irq_chk i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .uart_err_req, .uart_rx_req, .uart_tx_req,
  .channel_enable_status, .serial_output_on, .timer_count_run,
  .measure_clock_gate, .measure_circuit_run
);

// ---- sync2.v ----
// Two-flop synchroniser for levels entering from outside the hclk domain.
// Assumes the input is a slowly changing level.
`timescale 1ns/10ps

module sync2 #(
  parameter W = 1
) (
  hclk,
  hresetn,
  d,
  q
);
  input  wire         hclk;
  input  wire         hresetn;
  input  wire [W-1:0] d;
  output wire [W-1:0] q;

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule // sync2

// ---- tb_uart_timer_irq_and_channel_ctrl.sv ----
// Self-checking bench for chan_irq_ctrl over AHB-Lite.
// Assumes the design files and chan_irq_consts.vh are compiled first.
`timescale 1ns/10ps
`include "chan_irq_consts.vh"

module tb_uart_timer_irq_and_channel_ctrl;
  reg         hclk = 1'b0;
  reg         hresetn = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'b00;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'b010;
  reg  [31:0] hwdata = 32'h0;
  reg  [4:0]  ev = 5'h00;
  reg         pin_i = 1'b1;
  wire        hready;
  wire        hresp;
  wire [31:0] hrdata;
  wire [4:0]  req;
  wire [1:0]  ces;
  wire [1:0]  soe;
  wire        trun;
  wire        mgate;
  wire        mrun;
  wire [3:0]  p6;
  wire        pin_o;
  wire        pin_oe;
  integer     error_cnt = 0;
  integer     cmp_count = 0;
  integer     seed = 32'h3F74DE8E;
  integer     i;
  reg  [31:0] r;
  reg  [31:0] d;
  reg  [1:0]  st;

  always #25 hclk = ~hclk;

  chan_irq_ctrl i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
    .uart_err_evt(ev[4]), .uart_rx_evt(ev[3]), .uart_tx_evt(ev[2]),
    .timer_evt(ev[1]), .measure_evt(ev[0]), .uart_err_req(req[4]),
    .uart_rx_req(req[3]), .uart_tx_req(req[2]), .timer_req(req[1]),
    .measure_req(req[0]), .channel_enable_status(ces),
    .serial_output_on(soe), .timer_count_run(trun),
    .measure_clock_gate(mgate), .measure_circuit_run(mrun),
    .port_six_out(p6), .correction_indicator_pin_i(pin_i),
    .correction_indicator_pin_o(pin_o),
    .correction_indicator_pin_oe(pin_oe)
  );

  // ********
  // Bus, event and compare tasks
  // ********
  task xfer(input [7:0] a, input w, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      r = hrdata;
      #1;
    end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  // Channel enable status after one start or stop trigger write
  function [1:0] exp_status(input [1:0] s, input stop, input [1:0] b);
    begin
      exp_status = stop ? (s & ~b) : (s | b);
    end
  endfunction

  task rc(input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(r, e);
    end
  endtask

  task pulse(input [4:0] m);
    begin
      @(posedge hclk);
      ev <= m;
      @(posedge hclk);
      ev <= 5'h00;
      #1;
    end
  endtask

  task results;
    begin
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  initial begin
    #300000;
    error_cnt = error_cnt + 1;
    results;
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    chk({req, ces, soe, trun, mgate, mrun, p6, pin_oe}, 32'h0);
    rc(`OFS_UART_FLAGS, 32'h0);
    rc(`OFS_UART_MASKS, 32'h3E);
    rc(`OFS_TMR_MASKS, 32'h1);
    rc(`OFS_MEAS_MASKS, 32'h1);
    rc(`OFS_START_TRIG, 32'h0);
    rc(8'h3C, 32'h0);
    st = 2'b00;
    for (i = 0; i < 12; i = i + 1) begin
      d = $random(seed);
      xfer(d[2] ? `OFS_STOP_TRIG : `OFS_START_TRIG, 1'b1, {30'h0, d[1:0]});
      st = exp_status(st, d[2], d[1:0]);
      chk(ces, st);
    end
    rc(`OFS_CHAN_STATUS, st);
    for (i = 0; i < 3; i = i + 1) begin
      d = 32'h20 >> (i == 0 ? 0 : i + 2);
      xfer(`OFS_UART_FLAGS, 1'b1, 32'h0);
      xfer(`OFS_UART_MASKS, 1'b1, 32'h3E & ~d);
      pulse(5'h1C);
      rc(`OFS_UART_FLAGS, 32'h26);
      chk(req, {d[5], d[2], d[1], 2'b00});
      xfer(`OFS_UART_MASKS, 1'b1, 32'h3E);
      chk(req, 32'h0);
    end
    d = $random(seed);
    xfer(`OFS_SER_OUT_EN, 1'b1, d);
    chk(soe, d[1:0]);
    rc(`OFS_SER_OUT_EN, {30'h0, d[1:0]});
    xfer(`OFS_START_TRIG, 1'b1, 32'h3);
    xfer(`OFS_STOP_TRIG, 1'b1, 32'h3);
    xfer(`OFS_SER_OUT_EN, 1'b1, 32'h0);
    xfer(`OFS_UART_FLAGS, 1'b1, 32'h0);
    chk({ces, soe}, 32'h0);
    rc(`OFS_UART_FLAGS, 32'h0);
    pulse(5'h02);
    rc(`OFS_TMR_FLAGS, 32'h0);
    xfer(`OFS_TMR_CTRL, 1'b1, 32'h1);
    chk(trun, 32'h1);
    rc(`OFS_TMR_CTRL, 32'h1);
    xfer(`OFS_TMR_FLAGS, 1'b1, 32'h0);
    xfer(`OFS_TMR_MASKS, 1'b1, 32'h0);
    rc(`OFS_TMR_MASKS, 32'h0);
    pulse(5'h02);
    chk(req, 32'h02);
    xfer(`OFS_TMR_MASKS, 1'b1, 32'h1);
    chk(req, 32'h0);
    xfer(`OFS_TMR_FLAGS, 1'b1, 32'h0);
    rc(`OFS_TMR_FLAGS, 32'h0);
    xfer(`OFS_TMR_CTRL, 1'b1, 32'h0);
    chk(trun, 32'h0);
    xfer(`OFS_PER_ENABLE, 1'b1, 32'h40);
    chk(mgate, 32'h1);
    rc(`OFS_PER_ENABLE, 32'h40);
    xfer(`OFS_MEAS_CTRL, 1'b1, 32'h80);
    chk(mrun, 32'h1);
    rc(`OFS_MEAS_CTRL, 32'h80);
    xfer(`OFS_MEAS_FLAGS, 1'b1, 32'h0);
    xfer(`OFS_MEAS_MASKS, 1'b1, 32'h0);
    rc(`OFS_MEAS_MASKS, 32'h0);
    pulse(5'h01);
    chk(req, 32'h01);
    rc(`OFS_MEAS_FLAGS, 32'h1);
    xfer(`OFS_MEAS_FLAGS, 1'b1, 32'h0);
    chk(req, 32'h0);
    xfer(`OFS_PER_ENABLE, 1'b1, 32'h0);
    xfer(`OFS_MEAS_CTRL, 1'b1, 32'h0);
    chk({mgate, mrun}, 32'h0);
    xfer(`OFS_PORT6_MODE, 1'b1, 32'hE);
    xfer(`OFS_PORT6_DATA, 1'b1, 32'h0);
    chk({pin_oe, pin_o}, 32'h2);
    xfer(`OFS_PORT6_DATA, 1'b1, 32'h1);
    chk({pin_oe, pin_o}, 32'h3);
    chk(p6, 32'h1);
    rc(`OFS_PORT6_DATA, 32'h1);
    rc(`OFS_PORT6_MODE, 32'hE);
    xfer(`OFS_PORT6_MODE, 1'b1, 32'hF);
    chk(pin_oe, 32'h0);
    @(posedge hclk);
    pin_i <= 1'b0;
    rc(`OFS_PORT6_DATA, 32'h0);
    results;
  end
endmodule // tb_uart_timer_irq_and_channel_ctrl
